//--- rtl/eefe_pkg.sv
package eefe_pkg;
  localparam int NIRQ = 8;
  localparam int NEXC = 13;
  localparam logic [3:0] IDX_NMI  = 4'h0;
  localparam logic [3:0] IDX_HF   = 4'h1;
  localparam logic [3:0] IDX_MM   = 4'h2;
  localparam logic [3:0] IDX_BUS  = 4'h3;
  localparam logic [3:0] IDX_USE  = 4'h4;
  localparam logic [3:0] IDX_IRQ0 = 4'h5;
  localparam logic [7:0] EXCNUM_SYS_OFS = 8'h02;
  localparam logic [7:0] EXCNUM_IRQ_OFS = 8'h0B;
  localparam logic [31:0] VTOR_BASE = 32'h00000000;
  // register byte offsets
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_MASK  = 8'h04;
  localparam logic [7:0] A_PEND  = 8'h08;
  localparam logic [7:0] A_IPRI  = 8'h0C;
  localparam logic [7:0] A_FPRI  = 8'h10;
  localparam logic [7:0] A_HFC   = 8'h14;
  localparam logic [7:0] A_CFC   = 8'h18;
  localparam logic [7:0] A_MMLOC = 8'h1C;
  localparam logic [7:0] A_BFLOC = 8'h20;
  localparam logic [7:0] A_STAT  = 8'h24;
  localparam logic [7:0] A_IEN   = 8'h28;
  localparam int CTRL_ALIGN_BIT = 0;
  localparam int CTRL_SUB_LSB   = 1;
  localparam int CTRL_FEN_LSB   = 4;
  localparam logic [31:0] CTRL_RST = 32'h00000001;
  localparam int MASK_EN_BIT    = 4;
  localparam int HFC_VEC_BIT    = 1;
  localparam int HFC_ESCALATED_FAULT_FLAG_BIT = 30;
  localparam int CFC_MM_LSB  = 0;
  localparam int CFC_BUS_LSB = 8;
  localparam int CFC_USE_LSB = 16;
  localparam int C_XN = 0;
  localparam int C_IBUS = 0;
  localparam int C_DBUS = 1;
  localparam int C_STKBUS = 4;
  localparam int C_UNDEF = 0;
  localparam int C_STATE = 1;
  localparam logic [27:0] TOKEN_HI = 28'hFFFFFFF;
  localparam logic [3:0] RET_HANDLER = 4'h1;
  localparam logic [3:0] RET_THREAD_MAIN = 4'h9;
  localparam logic [3:0] RET_THREAD_PROC = 4'hD;
  localparam logic [2:0] FRAME_LAST = 3'h7;
  localparam logic [31:0] FRAME_BYTES = 32'h00000020;
  localparam logic [31:0] ALIGN_MASK = 32'hFFFFFFF8;
  localparam logic [4:0] THREAD_GRP = 5'h1F;
  localparam logic [4:0] CFG_GRP_OFS = 5'h02;
  typedef enum logic [2:0] {FK_IBUS, FK_DBUS, FK_UNDEF, FK_BXSTATE, FK_XN} eefe_fkind_t;
  typedef enum logic [2:0] {PL_OTHER, PL_POP, PL_BX, PL_LDR, PL_LDM} eefe_plkind_t;
  typedef struct packed {
    logic        valid;
    eefe_fkind_t kind;
    logic [31:0] addr;
  } eefe_fault_t;
  typedef struct packed {
    logic         valid;
    eefe_plkind_t kind;
    logic [31:0]  value;
  } eefe_pcload_t;
  typedef enum logic [5:0] {
    ST_RUN = 6'b000001, ST_STACK = 6'b000010, ST_VECT = 6'b000100,
    ST_LAUNCH = 6'b001000, ST_UNSTACK = 6'b010000, ST_LOCK = 6'b100000
  } eefe_state_t;
endpackage

//--- rtl/eefe_exc_unit.sv
module eefe_exc_unit
  import eefe_pkg::*;
(
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // ahb-lite slave
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic      [31:0]  hrdata,
  output logic              hreadyout,
  output logic              hresp,
  // exception sources
  input  wire logic [7:0]   irq_lines,
  input  wire logic         nmi_req,
  input  wire eefe_fault_t  fault_in,
  // pipeline
  input  wire eefe_pcload_t pc_load,
  input  wire logic [31:0]  sp_in,
  input  wire logic         psp_active,
  input  wire logic         first_exec,
  output logic              pipe_run,
  output logic              handler_start,
  output logic      [31:0]  handler_pc,
  output logic      [31:0]  link_register,
  output logic      [31:0]  sp_out,
  output logic              handler_mode,
  output logic              lockup,
  // stacking channel
  output logic              stk_req,
  output logic              stk_write,
  output logic      [2:0]   stk_slot,
  output logic      [31:0]  stk_addr,
  input  wire logic         stk_ack,
  input  wire logic         stk_err,
  // vector channel
  output logic              vec_req,
  output logic      [31:0]  vec_addr,
  input  wire logic         vec_ack,
  input  wire logic         vec_err,
  input  wire logic [31:0]  vec_data
);
  eefe_state_t       state_reg;
  logic [31:0]       ctrl_reg, ipri_reg, hfc_reg, mmloc_reg, bfloc_reg;
  logic [23:0]       cfc_reg;
  logic [11:0]       fpri_reg;
  logic [7:0]        ien_reg, wr_addr_reg;
  logic [4:0]        mask_reg;
  logic [NEXC-1:0]   pend_reg, pend_next, act_reg, act_next;
  logic [3:0]        tgt_reg, vec_ask_reg, vec_for_reg;
  logic              vec_have_reg, lock_nmi_reg, wr_pend_reg;
  logic [31:0]       vec_got_reg, rd_mux, frame_base;
  logic [8:0]        key_w [NEXC];
  logic [NEXC-1:0]   elig_w;
  logic              win_ok, cur_any;
  logic [3:0]        win_idx, cur_idx, fidx, ce_idx;
  logic [8:0]        win_key, cur_key;
  logic [4:0]        exec_grp, post_grp;
  logic [2:0]        sub_bits, fen_w;
  logic              flt_evt, stk_bus_evt, ce, esc, vec_err_evt, hf_now, lock_go;
  logic              ret_evt, entry_ok, tail_ok, late_ok, vec_ok, commit, ahb_wr;

  function automatic logic [7:0] exc_number(input logic [3:0] i);
    return (i < IDX_IRQ0) ? 8'(i) + EXCNUM_SYS_OFS : 8'(i) + EXCNUM_IRQ_OFS;
  endfunction

  assign sub_bits = (ctrl_reg[CTRL_SUB_LSB+:3] > 3'h4) ? 3'h4 : ctrl_reg[CTRL_SUB_LSB+:3];
  assign fen_w = ctrl_reg[CTRL_FEN_LSB+:3];

  // per-exception urgency key {group, sub}; lower compares as more urgent
  genvar g;
  generate
    for (g = 0; g < NEXC; g++) begin : g_key
      logic [3:0] raw, smask;
      logic       en;
      // enable bit only exists for lines; no negative index for system slots
      if (g < 2) begin : g_fix
        assign raw = 4'h0;
        assign en = 1'b1;
      end else if (g < 5) begin : g_flt
        assign raw = fpri_reg[4*(g-2)+:4];
        assign en = 1'b1;
      end else begin : g_irq
        assign raw = ipri_reg[4*(g-5)+:4];
        assign en = ien_reg[g-5];
      end
      assign smask = ~(4'hF << sub_bits);
      // fixed priorities sit below every configurable group
      assign key_w[g] = (g < 2) ? {5'(g), 4'h0}
                                : {5'(raw >> sub_bits) + CFG_GRP_OFS, raw & smask};
      // masked ones stay pending but are not eligible
      assign elig_w[g] = pend_reg[g] && en &&
                         (g < 2 || !mask_reg[MASK_EN_BIT] || raw < mask_reg[3:0]);
    end
  endgenerate

  // strict compare keeps the lowest index on ties
  always_comb begin
    win_ok = 1'b0;
    win_idx = 4'h0;
    win_key = 9'h1FF;
    for (int i = 0; i < NEXC; i++) begin
      if (elig_w[i] && (!win_ok || key_w[i] < win_key)) begin
        win_ok = 1'b1;
        win_idx = 4'(i);
        win_key = key_w[i];
      end
    end
  end

  always_comb begin
    cur_any = 1'b0;
    cur_idx = 4'h0;
    cur_key = 9'h1FF;
    post_grp = THREAD_GRP;
    for (int i = 0; i < NEXC; i++) begin
      if (act_reg[i] && (!cur_any || key_w[i] < cur_key)) begin
        cur_any = 1'b1;
        cur_idx = 4'(i);
        cur_key = key_w[i];
      end
    end
    for (int i = 0; i < NEXC; i++) begin
      if (act_reg[i] && 4'(i) != cur_idx && key_w[i][8:4] < post_grp) begin
        post_grp = key_w[i][8:4];
      end
    end
  end

  assign exec_grp = cur_any ? cur_key[8:4] : THREAD_GRP;
  assign entry_ok = win_ok && win_key[8:4] < exec_grp;
  assign tail_ok  = win_ok && win_key[8:4] < post_grp;
  assign late_ok  = win_ok && win_key[8:4] < key_w[tgt_reg][8:4];
  assign vec_ok   = vec_have_reg && vec_for_reg == tgt_reg && !vec_req;
  assign commit   = state_reg == ST_LAUNCH && first_exec;
  assign ret_evt  = state_reg == ST_RUN && cur_any && pc_load.valid &&
                    pc_load.kind != PL_OTHER && pc_load.value[31:4] == TOKEN_HI;

  always_comb begin
    case (fault_in.kind)
      FK_IBUS, FK_DBUS: fidx = IDX_BUS;
      FK_XN:            fidx = IDX_MM;
      default:          fidx = IDX_USE;
    endcase
  end

  // faults only come from executed code; stacking errors ride the bus fault path
  assign flt_evt = fault_in.valid && state_reg == ST_RUN;
  assign stk_bus_evt = state_reg == ST_STACK && stk_req && stk_err;
  assign ce = flt_evt || (stk_bus_evt && tgt_reg != IDX_BUS);
  assign ce_idx = flt_evt ? fidx : IDX_BUS;
  assign esc = !fen_w[2'(ce_idx - IDX_MM)] ||
               (cur_any && key_w[ce_idx][8:4] >= exec_grp);
  assign vec_err_evt = vec_req && vec_ack && vec_err;
  assign hf_now = vec_err_evt || (ce && esc);
  assign lock_go = hf_now && ((cur_any && cur_idx < IDX_MM) ||
                   (state_reg != ST_RUN && tgt_reg < IDX_MM));
  assign frame_base = ctrl_reg[CTRL_ALIGN_BIT] ? ((sp_in - FRAME_BYTES) & ALIGN_MASK)
                                               : (sp_in - FRAME_BYTES);

  // sources set last so a new arrival survives a same-cycle clear
  always_comb begin
    pend_next = pend_reg;
    if (commit) pend_next[tgt_reg] = 1'b0;
    if (ahb_wr && wr_addr_reg == A_PEND) pend_next[IDX_IRQ0+:NIRQ] &= ~hwdata[15:8];
    pend_next[IDX_IRQ0+:NIRQ] |= irq_lines;
    if (ahb_wr && wr_addr_reg == A_PEND) pend_next[IDX_IRQ0+:NIRQ] |= hwdata[7:0];
    if (nmi_req) pend_next[IDX_NMI] = 1'b1;
    if (hf_now) pend_next[IDX_HF] = 1'b1;
    else if (ce) pend_next[ce_idx] = 1'b1;
  end

  always_comb begin
    act_next = act_reg;
    if (commit) act_next[tgt_reg] = 1'b1;
    if (ret_evt) act_next[cur_idx] = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_reg <= '0;
      act_reg <= '0;
      handler_mode <= 1'b0;
    end else begin
      pend_reg <= pend_next;
      act_reg <= act_next;
      handler_mode <= |act_next;
    end
  end

  // sequencer, stacking channel and pipeline hand-off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_RUN;
      tgt_reg <= 4'h0;
      stk_req <= 1'b0;
      stk_write <= 1'b0;
      stk_slot <= 3'h0;
      stk_addr <= 32'h00000000;
      sp_out <= 32'h00000000;
      link_register <= 32'h00000000;
      handler_start <= 1'b0;
      handler_pc <= 32'h00000000;
      lockup <= 1'b0;
      lock_nmi_reg <= 1'b0;
    end else begin
      handler_start <= 1'b0;
      if (lock_go && state_reg != ST_LOCK) begin
        state_reg <= ST_LOCK;
        stk_req <= 1'b0;
        lockup <= 1'b1;
        lock_nmi_reg <= (cur_any && cur_idx == IDX_NMI) ||
                        (state_reg != ST_RUN && tgt_reg == IDX_NMI);
      end else begin
        case (state_reg)
          ST_RUN: begin
            if (ret_evt && tail_ok) begin
              state_reg <= ST_VECT;
              tgt_reg <= win_idx;
            end else if (ret_evt) begin
              state_reg <= ST_UNSTACK;
              stk_req <= 1'b1;
              stk_write <= 1'b0;
              stk_slot <= 3'h0;
              stk_addr <= sp_in;
            end else if (entry_ok) begin
              state_reg <= ST_STACK;
              tgt_reg <= win_idx;
              stk_req <= 1'b1;
              stk_write <= 1'b1;
              stk_slot <= 3'h0;
              stk_addr <= frame_base;
              sp_out <= frame_base;
              link_register <= {TOKEN_HI, cur_any ? RET_HANDLER :
                                psp_active ? RET_THREAD_PROC : RET_THREAD_MAIN};
            end
          end
          ST_STACK: begin
            if (stk_req && (stk_ack || stk_err)) begin
              if (stk_slot == FRAME_LAST) stk_req <= 1'b0;
              else begin
                stk_slot <= stk_slot + 3'h1;
                stk_addr <= stk_addr + 32'h00000004;
              end
            end
            if (late_ok) tgt_reg <= win_idx;
            else if (!stk_req && vec_ok) begin
              state_reg <= ST_LAUNCH;
              handler_start <= 1'b1;
              handler_pc <= vec_got_reg;
            end
          end
          ST_VECT: begin
            if (late_ok) tgt_reg <= win_idx;
            else if (vec_ok) begin
              state_reg <= ST_LAUNCH;
              handler_start <= 1'b1;
              handler_pc <= vec_got_reg;
            end
          end
          ST_LAUNCH: begin
            if (first_exec) state_reg <= ST_RUN;
            else if (late_ok) begin
              state_reg <= ST_VECT;
              tgt_reg <= win_idx;
            end
          end
          ST_UNSTACK: begin
            if (stk_ack || stk_err) begin
              stk_addr <= stk_addr + 32'h00000004;
              if (stk_slot == FRAME_LAST) begin
                stk_req <= 1'b0;
                state_reg <= ST_RUN;
                sp_out <= stk_addr + 32'h00000004;
              end else stk_slot <= stk_slot + 3'h1;
            end
          end
          default: begin
            // an nmi that locked up cannot be released by another nmi
            if (pend_reg[IDX_NMI] && !lock_nmi_reg) begin
              state_reg <= ST_RUN;
              lockup <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  assign pipe_run = state_reg[0];

  // vector channel; refetches whenever the target moves
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vec_req <= 1'b0;
      vec_addr <= 32'h00000000;
      vec_ask_reg <= 4'h0;
      vec_for_reg <= 4'h0;
      vec_have_reg <= 1'b0;
      vec_got_reg <= 32'h00000000;
    end else if (vec_req && vec_ack) begin
      vec_req <= 1'b0;
      vec_have_reg <= !vec_err;
      vec_got_reg <= vec_data;
      vec_for_reg <= vec_ask_reg;
    end else if (commit) begin
      vec_have_reg <= 1'b0;
    end else if ((state_reg == ST_STACK || state_reg == ST_VECT) && !vec_req &&
                 !(vec_have_reg && vec_for_reg == tgt_reg)) begin
      vec_req <= 1'b1;
      vec_ask_reg <= tgt_reg;
      vec_addr <= VTOR_BASE + {22'h0, exc_number(tgt_reg), 2'b00};
      vec_have_reg <= 1'b0;
    end
  end

  // fault cause and location capture; w1c with set winning
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hfc_reg <= 32'h00000000;
      cfc_reg <= 24'h000000;
      mmloc_reg <= 32'h00000000;
      bfloc_reg <= 32'h00000000;
    end else begin
      hfc_reg <= (hfc_reg & ~((ahb_wr && wr_addr_reg == A_HFC) ? hwdata : 32'h0))
                 | ((vec_err_evt ? 32'h1 : 32'h0) << HFC_VEC_BIT)
                 | (((ce && esc) ? 32'h1 : 32'h0) << HFC_ESCALATED_FAULT_FLAG_BIT);
      cfc_reg <= (cfc_reg & ~((ahb_wr && wr_addr_reg == A_CFC) ? hwdata[23:0] : 24'h0))
                 | ((stk_bus_evt ? 24'h1 : 24'h0) << (CFC_BUS_LSB + C_STKBUS))
                 | ((flt_evt && fault_in.kind == FK_IBUS ? 24'h1 : 24'h0) << (CFC_BUS_LSB + C_IBUS))
                 | ((flt_evt && fault_in.kind == FK_DBUS ? 24'h1 : 24'h0) << (CFC_BUS_LSB + C_DBUS))
                 | ((flt_evt && fault_in.kind == FK_UNDEF ? 24'h1 : 24'h0) << (CFC_USE_LSB + C_UNDEF))
                 | ((flt_evt && fault_in.kind == FK_BXSTATE ? 24'h1 : 24'h0) << (CFC_USE_LSB + C_STATE))
                 | ((flt_evt && fault_in.kind == FK_XN ? 24'h1 : 24'h0) << (CFC_MM_LSB + C_XN));
      if (flt_evt && fault_in.kind == FK_XN) mmloc_reg <= fault_in.addr;
      if (flt_evt && fidx == IDX_BUS) bfloc_reg <= fault_in.addr;
      else if (stk_bus_evt) bfloc_reg <= stk_addr;
    end
  end

  // ahb-lite: zero wait; read data latched in the address phase
  assign ahb_wr = wr_pend_reg;

  always_comb begin
    logic [7:0] a;
    a = haddr[7:0];
    if (a == A_CTRL) rd_mux = ctrl_reg;
    else if (a == A_MASK) rd_mux = {27'h0, mask_reg};
    else if (a == A_PEND) rd_mux = {3'h0, act_reg[4:0], 3'h0, pend_reg[4:0],
                                    act_reg[IDX_IRQ0+:NIRQ], pend_reg[IDX_IRQ0+:NIRQ]};
    else if (a == A_IPRI) rd_mux = ipri_reg;
    else if (a == A_FPRI) rd_mux = {20'h0, fpri_reg};
    else if (a == A_HFC) rd_mux = hfc_reg;
    else if (a == A_CFC) rd_mux = {8'h0, cfc_reg};
    else if (a == A_MMLOC) rd_mux = mmloc_reg;
    else if (a == A_BFLOC) rd_mux = bfloc_reg;
    else if (a == A_STAT) rd_mux = {lockup, 16'h0, state_reg, cur_any, exc_number(cur_idx)};
    else if (a == A_IEN) rd_mux = {24'h0, ien_reg};
    else rd_mux = 32'h00000000;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_reg <= hready && hsel && htrans[1] && hwrite;
      if (hready && hsel && htrans[1]) begin
        wr_addr_reg <= haddr[7:0];
        hrdata <= hwrite ? 32'h00000000 : rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= CTRL_RST;
      mask_reg <= 5'h00;
      ien_reg <= 8'h00;
      ipri_reg <= 32'h00000000;
      fpri_reg <= 12'h000;
    end else if (ahb_wr) begin
      if (wr_addr_reg == A_CTRL) ctrl_reg <= {25'h0, hwdata[6:0]};
      else if (wr_addr_reg == A_MASK) mask_reg <= hwdata[4:0];
      else if (wr_addr_reg == A_IEN) ien_reg <= hwdata[7:0];
      else if (wr_addr_reg == A_IPRI) ipri_reg <= hwdata;
      else if (wr_addr_reg == A_FPRI) fpri_reg <= hwdata[11:0];
    end
  end

  property p_token;
    @(posedge hclk) disable iff (!hresetn) handler_start |-> link_register[31:4] == TOKEN_HI;
  endproperty
  a_token: assert property (p_token) else $error("return token upper bits wrong");

  property p_align;
    @(posedge hclk) disable iff (!hresetn)
      (state_reg == ST_STACK && ctrl_reg[CTRL_ALIGN_BIT]) |-> sp_out[2:0] == 3'h0;
  endproperty
  a_align: assert property (p_align) else $error("frame not double-word aligned");

  property p_no_eq;
    @(posedge hclk) disable iff (!hresetn)
      (state_reg == ST_RUN && cur_any && win_ok && win_key[8:4] >= exec_grp && !ret_evt)
      |=> state_reg != ST_STACK;
  endproperty
  a_no_eq: assert property (p_no_eq) else $error("equal group preempted");

  property p_launch;
    @(posedge hclk) disable iff (!hresetn)
      $rose(handler_start) && $past(state_reg) == ST_STACK |-> $past(!stk_req);
  endproperty
  a_launch: assert property (p_launch) else $error("handler started before stacking done");

  property p_commit;
    @(posedge hclk) disable iff (!hresetn)
      commit |=> act_reg[$past(tgt_reg)] && !handler_start;
  endproperty
  a_commit: assert property (p_commit) else $error("exception not made active");

  property p_lock;
    @(posedge hclk) disable iff (!hresetn) lock_go |=> lockup && !pipe_run;
  endproperty
  a_lock: assert property (p_lock) else $error("lockup not entered");

  property p_escalated_fault_flag;
    @(posedge hclk) disable iff (!hresetn)
      (ce && esc) |=> hfc_reg[HFC_ESCALATED_FAULT_FLAG_BIT] && pend_reg[IDX_HF];
  endproperty
  a_escalated_fault_flag: assert property (p_escalated_fault_flag) else $error("escalation not flagged");

  property p_tail;
    @(posedge hclk) disable iff (!hresetn)
      (ret_evt && tail_ok && !lock_go) |=> state_reg == ST_VECT ##0 !stk_req;
  endproperty
  a_tail: assert property (p_tail) else $error("tail-chain unstacked");

  c_tail: cover property (@(posedge hclk) disable iff (!hresetn) ret_evt && tail_ok);
  c_late: cover property (@(posedge hclk) disable iff (!hresetn)
                          state_reg == ST_STACK && late_ok);
  c_lock: cover property (@(posedge hclk) disable iff (!hresetn) $rose(lockup));
  c_unstk: cover property (@(posedge hclk) disable iff (!hresetn)
                           state_reg == ST_UNSTACK ##1 state_reg == ST_RUN);
endmodule

//--- bench/eefe_far_side.sv
module eefe_far_side (
  // clock and requests
  input  wire logic        hclk,
  input  wire logic        stk_req,
  input  wire logic        vec_req,
  input  wire logic [31:0] vec_addr,
  // answers
  output logic             stk_ack,
  output logic             vec_ack,
  output logic      [31:0] vec_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    stk_ack = 1'b0;
    vec_ack = 1'b0;
    vec_data = 32'h00000000;
  end
  // random stalls model slow memory; idle data toggles so no stale word
  always @(posedge hclk) begin
    stk_ack <= 1'b0;
    vec_ack <= 1'b0;
    vec_data <= ~vec_data;
    if (stk_req && !stk_ack && $urandom_range(0, 2) == 0) stk_ack <= 1'b1;
    if (vec_req && !vec_ack && $urandom_range(0, 3) == 0) begin
      vec_ack <= 1'b1;
      vec_data <= vec_addr | 32'h00000001;
    end
  end
endmodule

//--- bench/test_exception_entry_fault_escalation.sv
module test_exception_entry_fault_escalation
  import eefe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic         hclk, hresetn, hsel, hwrite, first_exec, psp_active, idle;
  logic         stk_ack, vec_ack, hreadyout, pipe_run, handler_start;
  logic         handler_mode, stk_req, vec_req, hresp, lockup, stk_write;
  logic [2:0]   stk_slot;
  logic [31:0]  stk_addr;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic [7:0]   irq_lines;
  logic [31:0]  haddr, hwdata, sp_in, vec_data, rd, tok, hrdata;
  logic [31:0]  handler_pc, link_register, sp_out, vec_addr;
  eefe_pcload_t pc_load;
  logic [63:0]  exp_q[$];
  int           mismatches = 0, check_count = 0, slots = 0;
  eefe_exc_unit DUT (.hready(hreadyout), .nmi_req(1'b0), .fault_in('0), .stk_err(1'b0),
    .vec_err(1'b0), .*);
  eefe_far_side FAR (.*);
  always_comb idle = pipe_run & ~handler_mode;
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic await(ref logic s, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (s !== 1'b1 && n < lim);
    if (s !== 1'b1) begin
      mismatches++;
      results();
    end
  endtask
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'b10;
    await(hreadyout, 50);
    htrans <= 2'b00;
    hwdata <= d;
    await(hreadyout, 50);
    rd = hrdata;
  endtask
  task automatic run_and_return(input eefe_plkind_t k);
    await(handler_start, 300);
    first_exec <= 1'b1;
    @(posedge hclk);
    first_exec <= 1'b0;
    repeat (2) @(posedge hclk);
    pc_load <= '{1'b1, k, tok};
    @(posedge hclk);
    pc_load <= '0;
  endtask
  // each handler launch is matched against the oldest noted vector and token
  always @(posedge hclk) begin
    if (stk_req === 1'b1 && stk_ack === 1'b1) begin
      slots <= slots + 1;
      chk({stk_write, stk_slot, stk_addr}, {slots < 8, 3'(slots % 8),
          (slots < 8 ? (sp_in - FRAME_BYTES) & ALIGN_MASK : sp_in) + 32'(4 * (slots % 8))},
          "frame slot");
    end
    if (handler_start === 1'b1 && exp_q.size() == 0) chk(64'h0, 64'h1, "extra entry");
    else if (handler_start === 1'b1) chk({handler_pc, link_register}, exp_q.pop_front(), "entry");
  end
  initial begin
    rd = $urandom(32'hA8A97BC3);
    hresetn = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata, irq_lines, first_exec} = '0;
    hsize = 3'h2;
    pc_load = '0;
    sp_in = 32'h20000F00 | ($urandom & 32'h000000FC);
    psp_active = 1'($urandom);
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    @(posedge hclk);
    ahb(A_CTRL, 1'b0, 32'h0);
    chk(rd, CTRL_RST, "ctrl reset");
    ahb(8'h80, 1'b0, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    chk(hresp, 1'b0, "okay response");
    ahb(A_IPRI, 1'b1, 32'h00000012);
    ahb(A_IEN, 1'b1, 32'h000000FF);
    tok = {TOKEN_HI, psp_active ? RET_THREAD_PROC : RET_THREAD_MAIN};
    exp_q.push_back({32'h00000045, tok});
    exp_q.push_back({32'h00000041, tok});
    irq_lines <= 8'h03;
    @(posedge hclk);
    irq_lines <= 8'h00;
    run_and_return(PL_POP);
    chk(sp_out, (sp_in - FRAME_BYTES) & ALIGN_MASK, "stacked sp");
    run_and_return(PL_LDM);
    await(idle, 300);
    chk(sp_out, sp_in + FRAME_BYTES, "unstacked sp");
    chk(slots, 16, "frame words moved");
    chk(lockup, 1'b0, "no lockup");
    results();
  end
endmodule
